/* rtl/alpf_pkg.sv */
/*
  constants, states and a helper function for the local parameter frame interpreter.
  assumes one 25 MHz clock and byte-wide, already-deserialised receive and transmit streams.
*/
package alpf_pkg;
  localparam logic [7:0] ALPF_DELIM = 8'h7e;
  localparam logic [7:0] ALPF_ESC = 8'h7d;
  localparam logic [7:0] ALPF_ESC_XOR = 8'h20;
  localparam logic [7:0] ALPF_TYPE_NOW = 8'h08;
  localparam logic [7:0] ALPF_TYPE_QUEUE = 8'h09;
  localparam logic [7:0] ALPF_TYPE_RESP = 8'h88;
  localparam logic [7:0] ALPF_TYPE_STATUS = 8'h8a;
  localparam logic [7:0] ALPF_CK_GOOD = 8'hff;
  localparam logic [7:0] ALPF_ST_OK = 8'h00;
  localparam logic [7:0] ALPF_ST_BADCMD = 8'h02;
  localparam logic [7:0] ALPF_ST_BADPARAM = 8'h03;
  localparam logic [7:0] ALPF_ST_BADFRAME = 8'h04;
  localparam logic [15:0] ALPF_CMD_APPLY = 16'h4143;
  localparam logic [15:0] ALPF_CMD_RATE = 16'h4244;
  localparam logic [15:0] ALPF_CMD_JOIN = 16'h4e4a;
  localparam logic [15:0] ALPF_CMD_MODE = 16'h4150;
  localparam logic [31:0] ALPF_RATE_RST = 32'h0000_0003;
  localparam logic [31:0] ALPF_JOIN_RST = 32'h0000_00ff;
  localparam logic [31:0] ALPF_MODE_RST = 32'h0000_0001;
  localparam logic [31:0] ALPF_MODE_ESC = 32'h0000_0002;
  localparam logic [15:0] ALPF_MIN_LEN = 16'h0004;
  localparam logic [15:0] ALPF_MAX_LEN = 16'h0008;
  localparam logic [1:0] ALPF_IDX_RATE = 2'h0;
  localparam logic [1:0] ALPF_IDX_JOIN = 2'h1;
  localparam logic [1:0] ALPF_IDX_MODE = 2'h2;
  localparam logic [1:0] ALPF_IDX_NONE = 2'h3;
  localparam logic [3:0] ALPF_RESP_BASE = 4'h5;

  typedef enum logic [2:0] {
    ALPF_RX_HUNT = 3'b000,
    ALPF_RX_LEN_HI = 3'b001,
    ALPF_RX_LEN_LO = 3'b010,
    ALPF_RX_DATA = 3'b011,
    ALPF_RX_CK = 3'b100
  } alpf_rx_e;

  typedef enum logic [1:0] {
    ALPF_EX_IDLE = 2'b00,
    ALPF_EX_RUN = 2'b01,
    ALPF_EX_SEND = 2'b10
  } alpf_ex_e;

  // index of the parameter a character pair names
  function automatic logic [1:0] alpf_decode(input logic [15:0] cmd);
    unique case (cmd)
      ALPF_CMD_RATE: alpf_decode = ALPF_IDX_RATE;
      ALPF_CMD_JOIN: alpf_decode = ALPF_IDX_JOIN;
      ALPF_CMD_MODE: alpf_decode = ALPF_IDX_MODE;
      default: alpf_decode = ALPF_IDX_NONE;
    endcase
  endfunction
endpackage

/* rtl/alpf_rx_unescape.sv */
/*
  removes the escape prefix from the receive stream in escaped mode.
  assumes rx_valid pulses at most once a cycle with a byte; flags delimiters raw.
*/
module alpf_rx_unescape
  import alpf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw input
  input wire logic esc_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // cleaned output
  output logic out_valid,
  output logic out_delim,
  output logic [7:0] out_data
);
  logic pend_reg;
  logic pend_next;
  logic valid_reg;
  logic valid_next;
  logic delim_reg;
  logic delim_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;

  always_comb begin
    pend_next = pend_reg;
    valid_next = 1'b0;
    delim_next = 1'b0;
    data_next = data_reg;
    if (rx_valid) begin
      if (rx_data == ALPF_DELIM) begin
        // a raw delimiter always restarts, even mid-escape
        pend_next = 1'b0;
        valid_next = 1'b1;
        delim_next = 1'b1;
        data_next = rx_data;
      end else if (esc_mode && !pend_reg && rx_data == ALPF_ESC) begin
        pend_next = 1'b1;
      end else begin
        pend_next = 1'b0;
        valid_next = 1'b1;
        data_next = pend_reg ? (rx_data ^ ALPF_ESC_XOR) : rx_data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
      valid_reg <= 1'b0;
      delim_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      pend_reg <= pend_next;
      valid_reg <= valid_next;
      delim_reg <= delim_next;
      data_reg <= data_next;
    end
  end

  assign out_valid = valid_reg;
  assign out_delim = delim_reg;
  assign out_data = data_reg;

  property p_esc_undo;
    @(posedge ref_clk) disable iff (rst)
    (esc_mode && !pend_reg && rx_valid && rx_data == ALPF_ESC) ##1
    (rx_valid && rx_data != ALPF_DELIM) |=> (out_valid && out_data == ($past(rx_data) ^ 8'h20));
  endproperty
  a_esc_undo: assert property (p_esc_undo) else $error("escaped byte not restored");
endmodule

/* rtl/alpf_param_store.sv */
/*
  active and pending parameter values with an apply step.
  assumes at most one write per cycle from the executor; an apply may come in the same cycle and takes that write.
*/
module alpf_param_store
  import alpf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // requests
  input wire logic wr_en,
  input wire logic wr_queue,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wr_val,
  input wire logic apply,
  input wire logic [1:0] rd_idx,
  // values
  output logic [31:0] rd_val,
  output logic [31:0] rate_act,
  output logic [31:0] join_act,
  output logic [31:0] mode_act
);
  logic [31:0] act_reg [3];
  logic [31:0] act_next [3];
  logic [31:0] pend_reg [3];
  logic [31:0] pend_next [3];

  always_comb begin
    act_next = act_reg;
    pend_next = pend_reg;
    if (wr_en && wr_idx != ALPF_IDX_NONE) begin
      pend_next[wr_idx] = wr_val;
    end
    if (apply) begin
      act_next = pend_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      act_reg <= '{ALPF_RATE_RST, ALPF_JOIN_RST, ALPF_MODE_RST};
      pend_reg <= '{ALPF_RATE_RST, ALPF_JOIN_RST, ALPF_MODE_RST};
    end else begin
      act_reg <= act_next;
      pend_reg <= pend_next;
    end
  end

  // reads always show the active value: a queued write is invisible until applied
  assign rd_val = (rd_idx == ALPF_IDX_NONE) ? 32'h0 : act_reg[rd_idx];
  assign rate_act = act_reg[ALPF_IDX_RATE];
  assign join_act = act_reg[ALPF_IDX_JOIN];
  assign mode_act = act_reg[ALPF_IDX_MODE];

  property p_queue_holds;
    @(posedge ref_clk) disable iff (rst)
    (wr_en && wr_queue && !apply && wr_idx == ALPF_IDX_RATE) |=> $stable(rate_act);
  endproperty
  a_queue_holds: assert property (p_queue_holds) else $error("queued write changed rate");
endmodule

/* rtl/alpf_frame_cmd.sv */
/*
  local parameter command frame interpreter: receives framed requests, executes
  reads, writes and queued writes, and answers with response or status frames.
  assumes byte streams with a single-cycle rx strobe and a tx ready handshake.
*/
module alpf_frame_cmd
  import alpf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // receive byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // transmit byte stream (raw, unescaped)
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  // active parameter values
  output logic [31:0] serial_rate_param,
  output logic [31:0] join_window_param,
  output logic [31:0] framing_mode_param
);
  logic u_valid;
  logic u_delim;
  logic [7:0] u_data;
  logic st_wr_en;
  logic st_apply;
  logic [31:0] st_rd_val;
  logic [31:0] rate_w;
  logic [31:0] join_w;
  logic [31:0] mode_w;

  alpf_rx_unescape u_unesc (
    .ref_clk(ref_clk),
    .rst(rst),
    .esc_mode(mode_w == ALPF_MODE_ESC),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .out_valid(u_valid),
    .out_delim(u_delim),
    .out_data(u_data)
  );

  // receiver state
  alpf_rx_e rx_reg, rx_next;
  logic [15:0] len_reg, len_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0] sum_reg, sum_next;
  logic [7:0] type_reg, type_next;
  logic [7:0] fid_reg, fid_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [31:0] val_reg, val_next;
  logic [2:0] plen_reg, plen_next;
  logic done_reg, done_next;
  logic bad_reg, bad_next;

  always_comb begin
    rx_next = rx_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    sum_next = sum_reg;
    type_next = type_reg;
    fid_next = fid_reg;
    cmd_next = cmd_reg;
    val_next = val_reg;
    plen_next = plen_reg;
    done_next = 1'b0;
    bad_next = bad_reg;
    if (u_valid && u_delim) begin
      rx_next = ALPF_RX_LEN_HI;
      sum_next = 8'h00;
      cnt_next = 16'h0;
      val_next = 32'h0;
      plen_next = 3'h0;
    end else if (u_valid) begin
      unique case (rx_reg)
        ALPF_RX_HUNT: rx_next = ALPF_RX_HUNT;
        ALPF_RX_LEN_HI: begin
          len_next = {u_data, 8'h00};
          rx_next = ALPF_RX_LEN_LO;
        end
        ALPF_RX_LEN_LO: begin
          len_next = {len_reg[15:8], u_data};
          rx_next = ALPF_RX_DATA;
        end
        ALPF_RX_DATA: begin
          sum_next = sum_reg + u_data;
          cnt_next = cnt_reg + 16'h1;
          unique case (cnt_reg)
            16'h0: type_next = u_data;
            16'h1: fid_next = u_data;
            16'h2: cmd_next = {u_data, 8'h00};
            16'h3: cmd_next = {cmd_reg[15:8], u_data};
            default: begin
              val_next = {val_reg[23:0], u_data};
              plen_next = plen_reg + 3'h1;
            end
          endcase
          if (cnt_reg + 16'h1 == len_reg) rx_next = ALPF_RX_CK;
        end
        ALPF_RX_CK: begin
          bad_next = (8'(sum_reg + u_data) != ALPF_CK_GOOD) || len_reg < ALPF_MIN_LEN
            || len_reg > ALPF_MAX_LEN;
          done_next = 1'b1;
          rx_next = ALPF_RX_HUNT;
        end
        default: rx_next = ALPF_RX_HUNT;
      endcase
      if (rx_reg == ALPF_RX_LEN_LO && {len_reg[15:8], u_data} == 16'h0) rx_next = ALPF_RX_CK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_reg <= ALPF_RX_HUNT;
      len_reg <= 16'h0;
      cnt_reg <= 16'h0;
      sum_reg <= 8'h00;
      type_reg <= 8'h00;
      fid_reg <= 8'h00;
      cmd_reg <= 16'h0;
      val_reg <= 32'h0;
      plen_reg <= 3'h0;
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      rx_reg <= rx_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      sum_reg <= sum_next;
      type_reg <= type_next;
      fid_reg <= fid_next;
      cmd_reg <= cmd_next;
      val_reg <= val_next;
      plen_reg <= plen_next;
      done_reg <= done_next;
      bad_reg <= bad_next;
    end
  end

  // executor and reply serialiser
  alpf_ex_e ex_reg, ex_next;
  logic [7:0] obuf_reg [13];
  logic [7:0] obuf_next [13];
  logic [3:0] olen_reg, olen_next;
  logic [3:0] opos_reg, opos_next;
  logic [7:0] ock_reg, ock_next;
  logic tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic is_write;
  logic known_type;
  logic [1:0] idx;
  logic [7:0] status;
  logic [7:0] rsum;

  assign is_write = plen_reg != 3'h0;
  assign known_type = type_reg == ALPF_TYPE_NOW || type_reg == ALPF_TYPE_QUEUE;
  assign idx = alpf_decode(cmd_reg);
  // a 3-byte value is not a legal width; 1, 2 and 4 are zero-extended alike
  assign status = bad_reg || !known_type ? ALPF_ST_BADFRAME
    : (idx == ALPF_IDX_NONE && cmd_reg != ALPF_CMD_APPLY) ? ALPF_ST_BADCMD
    : (plen_reg == 3'h3 || plen_reg > 3'h4) ? ALPF_ST_BADPARAM : ALPF_ST_OK;
  assign st_wr_en = ex_reg == ALPF_EX_RUN && status == ALPF_ST_OK && is_write;
  assign st_apply = ex_reg == ALPF_EX_RUN && status == ALPF_ST_OK
    && (type_reg == ALPF_TYPE_NOW || cmd_reg == ALPF_CMD_APPLY);

  always_comb begin
    ex_next = ex_reg;
    obuf_next = obuf_reg;
    olen_next = olen_reg;
    opos_next = opos_reg;
    ock_next = ock_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    rsum = 8'h00;
    unique case (ex_reg)
      ALPF_EX_IDLE: if (done_reg) ex_next = ALPF_EX_RUN;
      ALPF_EX_RUN: begin
        obuf_next[0] = ALPF_DELIM;
        obuf_next[1] = 8'h00;
        obuf_next[3] = bad_reg ? ALPF_TYPE_STATUS : ALPF_TYPE_RESP;
        obuf_next[4] = bad_reg ? status : fid_reg;
        obuf_next[5] = cmd_reg[15:8];
        obuf_next[6] = cmd_reg[7:0];
        obuf_next[7] = status;
        obuf_next[8] = st_rd_val[31:24];
        obuf_next[9] = st_rd_val[23:16];
        obuf_next[10] = st_rd_val[15:8];
        obuf_next[11] = st_rd_val[7:0];
        if (bad_reg) begin
          obuf_next[2] = 8'h02;
          olen_next = 4'h5;
        end else if (is_write || idx == ALPF_IDX_NONE) begin
          obuf_next[2] = {4'h0, ALPF_RESP_BASE};
          olen_next = 4'h8;
        end else begin
          obuf_next[2] = 8'h09;
          olen_next = 4'hc;
        end
        for (int i = 3; i < 12; i++) begin
          if (4'(i) < olen_next) rsum = rsum + obuf_next[i];
        end
        ock_next = ALPF_CK_GOOD - rsum;
        opos_next = 4'h0;
        // a request with identifier zero and a good checksum and length runs but stays silent
        ex_next = (!bad_reg && fid_reg == 8'h00) ? ALPF_EX_IDLE : ALPF_EX_SEND;
      end
      ALPF_EX_SEND: begin
        // olen marks the checksum slot, so the reply is one byte longer than olen
        if (!tx_valid_reg || tx_ready) begin
          if (opos_reg == olen_reg + 4'h1) begin
            tx_valid_next = 1'b0;
            ex_next = ALPF_EX_IDLE;
          end else begin
            tx_valid_next = 1'b1;
            tx_data_next = (opos_reg == olen_reg) ? ock_reg : obuf_reg[opos_reg];
            opos_next = opos_reg + 4'h1;
          end
        end
      end
      default: ex_next = ALPF_EX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ex_reg <= ALPF_EX_IDLE;
      obuf_reg <= '{default: 8'h00};
      olen_reg <= 4'h0;
      opos_reg <= 4'h0;
      ock_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else begin
      ex_reg <= ex_next;
      obuf_reg <= obuf_next;
      olen_reg <= olen_next;
      opos_reg <= opos_next;
      ock_reg <= ock_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
    end
  end

  alpf_param_store u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(st_wr_en),
    .wr_queue(type_reg == ALPF_TYPE_QUEUE),
    .wr_idx(idx),
    .wr_val(val_reg),
    .apply(st_apply),
    .rd_idx(idx),
    .rd_val(st_rd_val),
    .rate_act(rate_w),
    .join_act(join_w),
    .mode_act(mode_w)
  );

  // outputs straight from flip-flops: tx from the serialiser, parameters from the store
  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign serial_rate_param = rate_w;
  assign join_window_param = join_w;
  assign framing_mode_param = mode_w;

  sequence s_silent_run;
    ex_reg == ALPF_EX_RUN && !bad_reg && fid_reg == 8'h00;
  endsequence
  property p_silent;
    @(posedge ref_clk) disable iff (rst)
    s_silent_run |=> !tx_valid [*8];
  endproperty
  a_silent: assert property (p_silent) else $error("reply sent for identifier zero");

  property p_fid_echo;
    @(posedge ref_clk) disable iff (rst)
    (ex_reg == ALPF_EX_RUN && !bad_reg && fid_reg != 8'h00) |=> obuf_reg[4] == $past(fid_reg);
  endproperty
  a_fid_echo: assert property (p_fid_echo) else $error("identifier not echoed");

  property p_now_applies;
    @(posedge ref_clk) disable iff (rst)
    (ex_reg == ALPF_EX_RUN && status == ALPF_ST_OK && type_reg == ALPF_TYPE_NOW) |-> st_apply;
  endproperty
  a_now_applies: assert property (p_now_applies) else $error("immediate frame did not apply");

  property p_hunt_drop;
    @(posedge ref_clk) disable iff (rst)
    (rx_reg == ALPF_RX_HUNT && !(u_valid && u_delim)) |=> rx_reg == ALPF_RX_HUNT;
  endproperty
  a_hunt_drop: assert property (p_hunt_drop) else $error("left hunt without delimiter");

  property p_len_order;
    @(posedge ref_clk) disable iff (rst)
    (rx_reg == ALPF_RX_LEN_HI && u_valid && !u_delim) |=> len_reg[15:8] == $past(u_data);
  endproperty
  a_len_order: assert property (p_len_order) else $error("length high byte misplaced");

  property p_bad_status;
    @(posedge ref_clk) disable iff (rst)
    (ex_reg == ALPF_EX_RUN && bad_reg) |=> obuf_reg[3] == ALPF_TYPE_STATUS ##0 ex_reg == ALPF_EX_SEND;
  endproperty
  a_bad_status: assert property (p_bad_status) else $error("bad frame not reported");

  property p_read_no_write;
    @(posedge ref_clk) disable iff (rst)
    (ex_reg == ALPF_EX_RUN && plen_reg == 3'h0) |-> !st_wr_en;
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read caused a write");

  property p_queue_wait;
    @(posedge ref_clk) disable iff (rst)
    (st_wr_en && type_reg == ALPF_TYPE_QUEUE && cmd_reg != ALPF_CMD_APPLY) |-> !st_apply;
  endproperty
  a_queue_wait: assert property (p_queue_wait) else $error("queued write applied at once");
endmodule

/* dv/alpf_host_model.sv */
/*
  host side of the serial command link: builds request frames, sends them byte by byte
  and collects every reply byte the block offers.
  assumes the bench calls frame and send hierarchically, and otherwise only sets slow and clears got_q here.
*/
module alpf_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // towards the block
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  // from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] alpf_hq_t[$];
  alpf_hq_t got_q;
  bit slow = 1'b0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end

  // a slow host drops tx_ready every other cycle
  always @(negedge ref_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  always @(posedge ref_clk) begin
    if (!rst && tx_valid && tx_ready) begin
      // every byte is kept whatever the frame type; the host never fails on one
      got_q.push_back(tx_data);
    end
  end

  function automatic alpf_hq_t frame(input logic [7:0] typ, input logic [7:0] id,
      input logic [15:0] cmd, input logic [39:0] val, input int nb, input bit with_cmd);
    alpf_hq_t q;
    logic [7:0] s;
    int n;
    q = {typ, id};
    if (with_cmd) begin
      q.push_back(cmd[15:8]);
      q.push_back(cmd[7:0]);
    end
    for (int i = nb - 1; i >= 0; i--) begin
      q.push_back(val[8*i +: 8]);
    end
    s = 8'h00;
    foreach (q[i]) s += q[i];
    n = q.size();
    q.push_back(8'hff - s);
    q.push_front(n[7:0]);
    q.push_front(n[15:8]);
    q.push_front(8'h7e);
    return q;
  endfunction

  task automatic put(input logic [7:0] b);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    if (slow) begin
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_data = ~b;
    end
  endtask

  task automatic send(input alpf_hq_t q, input bit esc);
    foreach (q[i]) begin
      if (esc && i > 0 && (q[i] == 8'h7e || q[i] == 8'h7d || q[i] == 8'h11 || q[i] == 8'h13))
          begin
        put(8'h7d);
        put(q[i] ^ 8'h20);
      end else begin
        put(q[i]);
      end
    end
    // a released data line must not keep showing the last byte
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule

/* dv/tb.sv */
/*
  self-checking bench for the parameter frame interpreter: reset, a table of ordinary requests,
  then framing faults, a stalling host, escaped mode and a mid-run reset.
  assumes the host model in alpf_host_model.sv and the design package.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alpf_pkg::*;
  typedef logic [7:0] alpf_bq_t[$];
  typedef struct {
    logic [7:0] typ;
    logic [7:0] id;
    logic [15:0] cmd;
    logic [31:0] val;
    int nb;
    bit rd;
    logic [7:0] st;
    logic [31:0] rate;
    logic [31:0] jwin;
  } alpf_row_s;

  logic ref_clk;
  logic rst;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic [31:0] serial_rate_param;
  logic [31:0] join_window_param;
  logic [31:0] framing_mode_param;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  alpf_bq_t f;
  alpf_bq_t e;
  alpf_row_s rows[11] = '{
    '{8'h08, 8'h01, ALPF_CMD_JOIN, 32'h40, 1, 0, ALPF_ST_OK, 32'h3, 32'h40},
    '{8'h08, 8'h02, ALPF_CMD_JOIN, 32'h40, 0, 1, ALPF_ST_OK, 32'h3, 32'h40},
    '{8'h09, 8'h03, ALPF_CMD_RATE, 32'h7, 1, 0, ALPF_ST_OK, 32'h3, 32'h40},
    '{8'h09, 8'h04, ALPF_CMD_JOIN, 32'h40, 0, 1, ALPF_ST_OK, 32'h3, 32'h40},
    '{8'h08, 8'h05, ALPF_CMD_APPLY, 32'h0, 0, 0, ALPF_ST_OK, 32'h7, 32'h40},
    '{8'h09, 8'h06, ALPF_CMD_JOIN, 32'h11, 2, 0, ALPF_ST_OK, 32'h7, 32'h40},
    '{8'h09, 8'h07, ALPF_CMD_APPLY, 32'h0, 0, 0, ALPF_ST_OK, 32'h7, 32'h11},
    '{8'h08, 8'h08, ALPF_CMD_RATE, 32'h5, 4, 0, ALPF_ST_OK, 32'h5, 32'h11},
    '{8'h08, 8'h09, 16'h5a5a, 32'h0, 0, 0, ALPF_ST_BADCMD, 32'h5, 32'h11},
    '{8'h08, 8'h00, ALPF_CMD_JOIN, 32'h22, 1, 0, ALPF_ST_OK, 32'h5, 32'h22},
    '{8'h08, 8'hfe, ALPF_CMD_RATE, 32'h5, 0, 1, ALPF_ST_OK, 32'h5, 32'h22}
  };

  alpf_frame_cmd dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .serial_rate_param(serial_rate_param),
    .join_window_param(join_window_param),
    .framing_mode_param(framing_mode_param)
  );

  alpf_host_model host_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_params(input logic [31:0] rate, input logic [31:0] jwin,
      input logic [31:0] mode);
    check("serial_rate_param", serial_rate_param, rate);
    check("join_window_param", join_window_param, jwin);
    check("framing_mode_param", framing_mode_param, mode);
  endtask

  // sends one frame and compares the whole reply; an empty expectation means silence
  task automatic run(input string name, input alpf_bq_t fr, input alpf_bq_t ex, input bit esc);
    host_u.got_q.delete();
    host_u.send(fr, esc);
    for (int k = 0; k < 300 && host_u.got_q.size() < ex.size(); k++) @(posedge ref_clk);
    // extra cycles catch bytes beyond the expected end
    repeat (20) @(posedge ref_clk);
    check({name, " reply size"}, host_u.got_q.size(), ex.size());
    foreach (ex[i]) check({name, " reply byte"}, host_u.got_q[i], ex[i]);
    $display("test %s done", name);
  endtask

  function automatic alpf_bq_t ok_reply(input logic [7:0] id, input logic [15:0] cmd,
      input logic [7:0] st);
    return host_u.frame(8'h88, id, cmd, {32'h0, st}, 1, 1'b1);
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("BAD run time expected below 20000 cycles seen %0d", cycles);
      results();
    end
  end

  initial begin
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    check_params(ALPF_RATE_RST, ALPF_JOIN_RST, ALPF_MODE_RST);
    check("tx_valid in reset", tx_valid, 1'b0);
    rst = 1'b0;
    @(negedge ref_clk);
    check_params(ALPF_RATE_RST, ALPF_JOIN_RST, ALPF_MODE_RST);
    $display("test reset done");

    foreach (rows[r]) begin
      f = host_u.frame(rows[r].typ, rows[r].id, rows[r].cmd, {8'h00, rows[r].val},
          rows[r].nb, 1'b1);
      if (rows[r].id == 8'h00) begin
        e = {};
      end else if (rows[r].rd) begin
        e = host_u.frame(8'h88, rows[r].id, rows[r].cmd, {rows[r].st, rows[r].val}, 5, 1'b1);
      end else begin
        e = ok_reply(rows[r].id, rows[r].cmd, rows[r].st);
      end
      run($sformatf("row %0d", r), f, e, 1'b0);
      check_params(rows[r].rate, rows[r].jwin, ALPF_MODE_RST);
    end

    // noise ahead of the delimiter, including a byte that looks like a length
    f = host_u.frame(8'h08, 8'h21, ALPF_CMD_JOIN, 40'h0, 0, 1'b1);
    f = {8'h13, 8'h00, 8'h05, f};
    e = host_u.frame(8'h88, 8'h21, ALPF_CMD_JOIN, 40'h00_0000_0022, 5, 1'b1);
    run("noise before delimiter", f, e, 1'b0);

    e = host_u.frame(8'h8a, ALPF_ST_BADFRAME, 16'h0, 40'h0, 0, 1'b0);
    f = host_u.frame(8'h08, 8'h22, ALPF_CMD_RATE, 40'h9, 1, 1'b1);
    f[f.size() - 1] = f[f.size() - 1] ^ 8'h01;
    run("bad checksum", f, e, 1'b0);
    check("rate after bad checksum", serial_rate_param, 32'h5);
    f = {8'h7e, 8'h00, 8'h03, 8'h08, 8'h01, 8'h4e, 8'ha8};
    run("short length", f, e, 1'b0);

    f = host_u.frame(8'h08, 8'h23, ALPF_CMD_RATE, 40'h05, 3, 1'b1);
    run("three byte value", f, ok_reply(8'h23, ALPF_CMD_RATE, ALPF_ST_BADPARAM), 1'b0);

    // an unrecognised frame type is refused and must not touch the store
    f = host_u.frame(8'h10, 8'h27, ALPF_CMD_JOIN, 40'h33, 1, 1'b1);
    run("unknown type", f, ok_reply(8'h27, ALPF_CMD_JOIN, ALPF_ST_BADFRAME), 1'b0);
    check("join after unknown type", join_window_param, 32'h22);

    host_u.slow = 1'b1;
    f = host_u.frame(8'h08, 8'h24, ALPF_CMD_RATE, 40'h0, 0, 1'b1);
    e = host_u.frame(8'h88, 8'h24, ALPF_CMD_RATE, 40'h00_0000_0005, 5, 1'b1);
    run("stalling host", f, e, 1'b0);
    host_u.slow = 1'b0;

    f = host_u.frame(8'h08, 8'h25, ALPF_CMD_MODE, 40'h02, 1, 1'b1);
    run("enter escaped mode", f, ok_reply(8'h25, ALPF_CMD_MODE, ALPF_ST_OK), 1'b0);
    check("mode after write", framing_mode_param, ALPF_MODE_ESC);
    f = host_u.frame(8'h08, 8'h11, ALPF_CMD_JOIN, 40'h7d, 1, 1'b1);
    run("escaped write", f, ok_reply(8'h11, ALPF_CMD_JOIN, ALPF_ST_OK), 1'b1);
    check("join after escaped write", join_window_param, 32'h7d);

    // a reset in mid-run must drop every applied value
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    check_params(ALPF_RATE_RST, ALPF_JOIN_RST, ALPF_MODE_RST);
    rst = 1'b0;
    f = host_u.frame(8'h08, 8'h26, ALPF_CMD_JOIN, 40'h0, 0, 1'b1);
    e = host_u.frame(8'h88, 8'h26, ALPF_CMD_JOIN, {8'h00, ALPF_JOIN_RST}, 5, 1'b1);
    run("after second reset", f, e, 1'b0);
    results();
  end
endmodule
